// file: special_register_space_pkg.sv
// Constants for the special register space: window, map, offsets and reset image
package special_register_space_pkg;

  // Window of the special register space in the direct address map
  localparam logic [7:0]   SPACE_BASE      = 8'h80;
  localparam int           SPACE_SIZE      = 128;
  localparam int           OCCUPIED_COUNT  = 106;
  localparam int           BIT_REG_COUNT   = 16;
  localparam int           LOCAL_COUNT     = 20;
  localparam logic [4:0]   LOCAL_COUNT_W5  = 5'h14;

  // Bit i stands for address SPACE_BASE + i; a one marks a reserved location
  localparam logic [127:0] RESERVED_MAP    = 128'h7efe_0000_0000_0000_0000_0003_dc00_0011;
  // Bit i stands for address SPACE_BASE + 8*i; a one marks a bit-addressable register
  localparam logic [15:0]  BIT_ADDR_MAP    = 16'hffff;

  // Register offsets (absolute direct addresses)
  localparam logic [7:0] STACK_POINTER_OFS           = 8'h81;
  localparam logic [7:0] DATA_POINTER_LOW_OFS        = 8'h82;
  localparam logic [7:0] DATA_POINTER_HIGH_OFS       = 8'h83;
  localparam logic [7:0] DUAL_POINTER_CONTROL_OFS    = 8'h85;
  localparam logic [7:0] DUAL_POINTER_MODE_OFS       = 8'h86;
  localparam logic [7:0] POWER_CONTROL_OFS           = 8'h87;
  localparam logic [7:0] TIMER_CONTROL_OFS           = 8'h88;
  localparam logic [7:0] TIMER_MODE_OFS              = 8'h89;
  localparam logic [7:0] TIMER0_COUNT_LOW_OFS        = 8'h8a;
  localparam logic [7:0] TIMER1_COUNT_LOW_OFS        = 8'h8b;
  localparam logic [7:0] TIMER0_COUNT_HIGH_OFS       = 8'h8c;
  localparam logic [7:0] TIMER1_COUNT_HIGH_OFS       = 8'h8d;
  localparam logic [7:0] PORT1_FUNCTION_SELECT_A_OFS = 8'h8e;
  localparam logic [7:0] PORT1_FUNCTION_SELECT_B_OFS = 8'h8f;
  localparam logic [7:0] PORT1_LATCH_OFS             = 8'h90;
  localparam logic [7:0] PORT3_FUNCTION_SELECT_OFS   = 8'h91;
  localparam logic [7:0] PORT4_FUNCTION_SELECT_A_OFS = 8'h92;
  localparam logic [7:0] PORT4_FUNCTION_SELECT_B_OFS = 8'h93;

  // Reset values
  localparam logic [7:0] STACK_POINTER_RST = 8'h07;
  localparam logic [7:0] PORT1_LATCH_RST   = 8'hff;
  localparam logic [7:0] DEFAULT_RST       = 8'h00;
  // Value driven for reads that no local register answers
  localparam logic [7:0] UNMAPPED_READ     = 8'h00;

endpackage

// file: special_register_addr_decode.sv
// Address decoder for direct byte and bit accesses to the special register space
module special_register_addr_decode #(
  parameter logic [127:0] RESERVED   = special_register_space_pkg::RESERVED_MAP,
  parameter logic [15:0]  BIT_MAP    = special_register_space_pkg::BIT_ADDR_MAP,
  parameter int           LOCAL_REGS = special_register_space_pkg::LOCAL_COUNT
) (
  input  wire logic [7:0] direct_addr_i,
  input  wire logic       bit_mode_i,
  input  wire logic       indirect_i,
  output logic            in_space_o,
  output logic            occupied_o,
  output logic            bit_capable_o,
  output logic            local_hit_o,
  output logic [4:0]      local_index_o,
  output logic [2:0]      bit_index_o
);

  logic [7:0] reg_addr;
  logic [6:0] slot;

  // The five-bit bank index cannot reach more than 32 local registers
  if (LOCAL_REGS < 1 || LOCAL_REGS > 32) begin : g_chk_local
    $error("local register count must lie between 1 and 32");
  end

  // Bit addresses 80h and up name bit (addr & 7) of the register at (addr & F8h)
  assign reg_addr    = bit_mode_i ? {direct_addr_i[7:3], 3'b000} : direct_addr_i;
  assign bit_index_o = direct_addr_i[2:0];
  assign slot        = reg_addr[6:0];

  // Only direct accesses at 80h and above land here; indirect ones go to data memory
  assign in_space_o    = reg_addr[7] & ~indirect_i;
  // Reserved holes hold nothing, so writes there drop and reads are undefined
  assign occupied_o    = in_space_o & ~RESERVED[slot];
  // Bit operations reach only the aligned bit-addressable registers
  assign bit_capable_o = occupied_o & (slot[2:0] == 3'b000) & BIT_MAP[slot[6:3]];
  assign local_hit_o   = occupied_o & (int'(slot) < LOCAL_REGS)
                         & (~bit_mode_i | bit_capable_o);
  assign local_index_o = slot[4:0];

endmodule // special_register_addr_decode

// file: special_register_bit_merge.sv
// Read-modify-write merge of one bit into a register byte
module special_register_bit_merge (
  input  wire logic [7:0] old_byte_i,
  input  wire logic [2:0] bit_index_i,
  input  wire logic       bit_value_i,
  output logic [7:0]      new_byte_o,
  output logic            old_bit_o
);

  // One generate lane per bit; only the selected lane takes the new value
  for (genvar b = 0; b < 8; b++) begin : g_lane
    assign new_byte_o[b] = (bit_index_i == 3'(b)) ? bit_value_i : old_byte_i[b];
  end

  assign old_bit_o = old_byte_i[bit_index_i];

endmodule // special_register_bit_merge

// file: special_register_space_decode.sv
// Special register space: access decode and the low register bank (80h-93h)
//
// Summary of operation
// - Only direct accesses 80h-FFh reach these registers.
// - Fourteen registers take bit access (80h and A0h are holes); others byte only.
// - 106 of 128 locations hold registers.
// - Reading reserved locations returns an undefined value.
// - Programmable logic module is not controlled here.
// - Stack pointer resets to 07h.
module special_register_space_decode #(
  parameter logic [127:0] RESERVED = special_register_space_pkg::RESERVED_MAP,
  parameter logic [15:0]  BIT_MAP  = special_register_space_pkg::BIT_ADDR_MAP
) (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  direct_addr_i,
  input  wire logic        indirect_i,
  input  wire logic        byte_rd_i,
  input  wire logic        byte_wr_i,
  input  wire logic        bit_rd_i,
  input  wire logic        bit_wr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        bit_wdata_i,
  output logic [7:0]       rdata_o,
  output logic             bit_rdata_o,
  output logic             rvalid_o,
  output logic             occupied_o,
  output logic             local_hit_o,
  output logic             bit_capable_o,
  output logic [7:0]       stack_pointer_o,
  output logic [7:0]       data_pointer_low_o,
  output logic [7:0]       data_pointer_high_o,
  output logic [7:0]       dual_pointer_control_o,
  output logic [7:0]       dual_pointer_mode_o,
  output logic [7:0]       power_control_o,
  output logic [7:0]       timer_control_o,
  output logic [7:0]       timer_mode_o,
  output logic [7:0]       timer0_count_low_o,
  output logic [7:0]       timer1_count_low_o,
  output logic [7:0]       timer0_count_high_o,
  output logic [7:0]       timer1_count_high_o,
  output logic [7:0]       port1_function_select_a_o,
  output logic [7:0]       port1_function_select_b_o,
  output logic [7:0]       port1_latch_o,
  output logic [7:0]       port3_function_select_o,
  output logic [7:0]       port4_function_select_a_o,
  output logic [7:0]       port4_function_select_b_o
);

  localparam int NREG = special_register_space_pkg::LOCAL_COUNT;

  // Refuse maps that break the documented occupancy or bit-access counts
  if ($countones(~RESERVED) != special_register_space_pkg::OCCUPIED_COUNT) begin : g_chk_occ
    $error("occupancy map must mark exactly 106 occupied locations");
  end
  if ($countones(BIT_MAP) != special_register_space_pkg::BIT_REG_COUNT) begin : g_chk_bit
    $error("bit map must mark exactly sixteen bit-addressable registers");
  end
  if (RESERVED[0] != 1'b1 || RESERVED[4] != 1'b1) begin : g_chk_holes
    $error("locations 80h and 84h hold no register in the low bank");
  end

  // Complete state of the block
  typedef struct packed {
    logic [NREG-1:0][7:0] regs;
    logic [7:0]           rdata;
    logic                 bit_rdata;
    logic                 rvalid;
  } state_t;

  state_t state;
  state_t next_state;

  logic       occupied;
  logic       bit_capable;
  logic       local_hit;
  logic [4:0] local_index;
  logic [2:0] bit_index;
  logic       bit_mode;
  logic [7:0] cur_byte;
  logic [7:0] merged_byte;
  logic       cur_bit;

  // Index of an absolute offset inside the low bank
  function automatic logic [4:0] slot_of(input logic [7:0] ofs);
    slot_of = ofs[4:0];
  endfunction

  // Reset image: stack pointer 07h, port 1 latch FFh, everything else 00h
  function automatic logic [NREG-1:0][7:0] reset_image();
    logic [NREG-1:0][7:0] img;
    img = '0;
    for (int i = 0; i < NREG; i++) begin
      img[i] = special_register_space_pkg::DEFAULT_RST;
    end
    img[slot_of(special_register_space_pkg::STACK_POINTER_OFS)] =
      special_register_space_pkg::STACK_POINTER_RST;
    img[slot_of(special_register_space_pkg::PORT1_LATCH_OFS)] =
      special_register_space_pkg::PORT1_LATCH_RST;
    reset_image = img;
  endfunction

  assign bit_mode = bit_rd_i | bit_wr_i;

  // Address decode shared by byte and bit paths
  special_register_addr_decode #(
    .RESERVED   (RESERVED),
    .BIT_MAP    (BIT_MAP),
    .LOCAL_REGS (NREG)
  ) u_decode (
    .direct_addr_i (direct_addr_i),
    .bit_mode_i    (bit_mode),
    .indirect_i    (indirect_i),
    .in_space_o    (),
    .occupied_o    (occupied),
    .bit_capable_o (bit_capable),
    .local_hit_o   (local_hit),
    .local_index_o (local_index),
    .bit_index_o   (bit_index)
  );

  // Current byte of the addressed register; zero when nothing local is hit
  assign cur_byte = local_hit ? state.regs[local_index]
                              : special_register_space_pkg::UNMAPPED_READ;

  // Bit write path works on the addressed byte
  special_register_bit_merge u_merge (
    .old_byte_i  (cur_byte),
    .bit_index_i (bit_index),
    .bit_value_i (bit_wdata_i),
    .new_byte_o  (merged_byte),
    .old_bit_o   (cur_bit)
  );

  // Next state: writes land in the bank, reads are captured for the next cycle
  always_comb begin
    next_state        = state;
    next_state.rvalid = byte_rd_i | bit_rd_i;
    // Byte write; reserved and unimplemented locations drop the write silently
    if (byte_wr_i && local_hit) begin
      next_state.regs[local_index] = wdata_i;
    end
    // Bit write; only the aligned local registers 88h and 90h accept it
    if (bit_wr_i && local_hit && bit_capable) begin
      next_state.regs[local_index] = merged_byte;
    end
    // Reserved reads give UNMAPPED_READ (00h); the core must not rely on it
    if (byte_rd_i) begin
      next_state.rdata = local_hit ? cur_byte
                                   : special_register_space_pkg::UNMAPPED_READ;
    end
    if (bit_rd_i) begin
      next_state.bit_rdata = local_hit & bit_capable & cur_bit;
    end
    if (reset_i) begin
      next_state.regs      = reset_image();
      next_state.rdata     = special_register_space_pkg::DEFAULT_RST;
      next_state.bit_rdata = 1'b0;
      next_state.rvalid    = 1'b0;
    end
  end

  // Single state register
  always_ff @(posedge sys_clk_i) begin
    state <= next_state;
  end

  // Decode status toward the core; other blocks own occupied registers above 93h
  assign occupied_o    = occupied;
  assign local_hit_o   = local_hit;
  assign bit_capable_o = bit_capable;
  assign rdata_o       = state.rdata;
  assign bit_rdata_o   = state.bit_rdata;
  assign rvalid_o      = state.rvalid;

  // Register fields toward the core and peripherals; no path leads to the
  // programmable logic module, which keeps its own control set
  assign stack_pointer_o = state.regs[slot_of(special_register_space_pkg::STACK_POINTER_OFS)];
  assign data_pointer_low_o =
    state.regs[slot_of(special_register_space_pkg::DATA_POINTER_LOW_OFS)];
  assign data_pointer_high_o =
    state.regs[slot_of(special_register_space_pkg::DATA_POINTER_HIGH_OFS)];
  assign dual_pointer_control_o =
    state.regs[slot_of(special_register_space_pkg::DUAL_POINTER_CONTROL_OFS)];
  assign dual_pointer_mode_o =
    state.regs[slot_of(special_register_space_pkg::DUAL_POINTER_MODE_OFS)];
  assign power_control_o = state.regs[slot_of(special_register_space_pkg::POWER_CONTROL_OFS)];
  assign timer_control_o = state.regs[slot_of(special_register_space_pkg::TIMER_CONTROL_OFS)];
  assign timer_mode_o    = state.regs[slot_of(special_register_space_pkg::TIMER_MODE_OFS)];
  assign timer0_count_low_o =
    state.regs[slot_of(special_register_space_pkg::TIMER0_COUNT_LOW_OFS)];
  assign timer1_count_low_o =
    state.regs[slot_of(special_register_space_pkg::TIMER1_COUNT_LOW_OFS)];
  assign timer0_count_high_o =
    state.regs[slot_of(special_register_space_pkg::TIMER0_COUNT_HIGH_OFS)];
  assign timer1_count_high_o =
    state.regs[slot_of(special_register_space_pkg::TIMER1_COUNT_HIGH_OFS)];
  assign port1_function_select_a_o =
    state.regs[slot_of(special_register_space_pkg::PORT1_FUNCTION_SELECT_A_OFS)];
  assign port1_function_select_b_o =
    state.regs[slot_of(special_register_space_pkg::PORT1_FUNCTION_SELECT_B_OFS)];
  assign port1_latch_o = state.regs[slot_of(special_register_space_pkg::PORT1_LATCH_OFS)];
  assign port3_function_select_o =
    state.regs[slot_of(special_register_space_pkg::PORT3_FUNCTION_SELECT_OFS)];
  assign port4_function_select_a_o =
    state.regs[slot_of(special_register_space_pkg::PORT4_FUNCTION_SELECT_A_OFS)];
  assign port4_function_select_b_o =
    state.regs[slot_of(special_register_space_pkg::PORT4_FUNCTION_SELECT_B_OFS)];

endmodule // special_register_space_decode

// file: special_register_space_decode_chk.sv
// Assertion checker for the special register space decode block
module special_register_space_decode_chk #(
  parameter logic [127:0] RESERVED = special_register_space_pkg::RESERVED_MAP
) (
  input wire logic       sys_clk_i,
  input wire logic       reset_i,
  input wire logic [7:0] direct_addr_i,
  input wire logic       indirect_i,
  input wire logic       byte_rd_i,
  input wire logic       byte_wr_i,
  input wire logic       bit_rd_i,
  input wire logic       bit_wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       bit_wdata_i,
  input wire logic       rvalid_o,
  input wire logic       occupied_o,
  input wire logic       local_hit_o,
  input wire logic       bit_capable_o,
  input wire logic [7:0] stack_pointer_o,
  input wire logic [7:0] timer_control_o,
  input wire logic [7:0] port1_latch_o
);
  // One clock domain, so clock and disable are given once
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  AST_RVALID: assert property ((byte_rd_i || bit_rd_i) |=> rvalid_o)
    else $error("read not answered");
  AST_NO_RVALID: assert property (!(byte_rd_i || bit_rd_i) |=> !rvalid_o)
    else $error("answer without read");
  AST_OUT_RANGE: assert property ((indirect_i || !direct_addr_i[7])
    |-> !occupied_o && !local_hit_o)
    else $error("decode outside direct window");
  AST_OCCUPIED: assert property (!indirect_i && direct_addr_i[7] && !bit_rd_i && !bit_wr_i
    |-> occupied_o == !RESERVED[direct_addr_i[6:0]])
    else $error("occupancy mismatch");
  AST_BYTE_ONLY: assert property (byte_rd_i && !bit_rd_i && !bit_wr_i && direct_addr_i[2:0] != 3'h0
    |-> !bit_capable_o)
    else $error("unaligned register flagged bit capable");
  // Reset check must see the reset itself, so it overrides the default disable
  AST_RESET: assert property (disable iff (1'b0) reset_i |=> stack_pointer_o == 8'h07
    && port1_latch_o == 8'hff && timer_control_o == 8'h00)
    else $error("wrong reset value");
  AST_LATCH_WR: assert property (byte_wr_i && !bit_wr_i && !indirect_i && direct_addr_i == 8'h90
    |=> port1_latch_o == $past(wdata_i))
    else $error("latch write lost");
  AST_BIT_WR: assert property (bit_wr_i && !indirect_i && direct_addr_i[7:3] == 5'h11
    |=> timer_control_o[$past(direct_addr_i[2:0])] == $past(bit_wdata_i))
    else $error("bit write lost");
  AST_INDIRECT: assert property ((byte_wr_i || bit_wr_i) && indirect_i |=> $stable(port1_latch_o)
    && $stable(timer_control_o) && $stable(stack_pointer_o))
    else $error("indirect write reached a register");
endmodule // special_register_space_decode_chk

bind special_register_space_decode
  special_register_space_decode_chk #(.RESERVED(RESERVED)) chk_i (.*);

// file: core_access_model.sv
// Core-side model issuing direct byte and bit accesses
module core_access_model (
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rbit_i,
  input  wire logic       rvalid_i,
  output logic [7:0]      addr_o,
  output logic            ind_o,
  output logic [3:0]      op_o,
  output logic [7:0]      wdat_o,
  output logic            wbit_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {addr_o, ind_o, op_o, wdat_o, wbit_o} = '0;
  end
  // Drive after a falling edge, hold over the taking edge, collect one cycle later
  task automatic access(input logic [3:0] op, input logic ind, input logic [7:0] a, d,
                        output logic [7:0] rd, output logic rb, output logic rv);
    logic [3:0] o;
    o = op;
    if (!ind && a[7] && special_register_space_pkg::RESERVED_MAP[a[6:0]]) o[1] = 1'b0;
    @(negedge sys_clk_i);
    addr_o = a;
    ind_o = ind;
    wdat_o = d;
    wbit_o = d[0];
    op_o = o;
    @(negedge sys_clk_i);
    rd = rdata_i;
    rb = rbit_i;
    rv = rvalid_i;
    op_o = 4'h0;
  endtask
endmodule // core_access_model

// file: tb_special_register_space_decode.sv
// Self-checking bench for the special register space decode block
module tb_special_register_space_decode;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk_i, reset_i, ind, wbit, rbit, rvalid, occ, hit, cap, rb, rv, eo;
  logic [7:0] addr, wdat, rdata, rd;
  logic [3:0] op;
  logic [7:0] regs [20];
  int         exp_reg [256];
  int         error_cnt, cmp_count, cycles, n;

  special_register_space_decode special_register_space_decode_i (
    .sys_clk_i, .reset_i, .direct_addr_i(addr), .indirect_i(ind), .byte_rd_i(op[0]),
    .byte_wr_i(op[1]), .bit_rd_i(op[2]), .bit_wr_i(op[3]), .wdata_i(wdat), .bit_wdata_i(wbit),
    .rdata_o(rdata), .bit_rdata_o(rbit), .rvalid_o(rvalid), .occupied_o(occ), .local_hit_o(hit),
    .bit_capable_o(cap), .stack_pointer_o(regs[1]), .data_pointer_low_o(regs[2]),
    .data_pointer_high_o(regs[3]), .dual_pointer_control_o(regs[5]),
    .dual_pointer_mode_o(regs[6]), .power_control_o(regs[7]), .timer_control_o(regs[8]),
    .timer_mode_o(regs[9]), .timer0_count_low_o(regs[10]), .timer1_count_low_o(regs[11]),
    .timer0_count_high_o(regs[12]), .timer1_count_high_o(regs[13]),
    .port1_function_select_a_o(regs[14]), .port1_function_select_b_o(regs[15]),
    .port1_latch_o(regs[16]), .port3_function_select_o(regs[17]),
    .port4_function_select_a_o(regs[18]), .port4_function_select_b_o(regs[19]));
  core_access_model core_access_model_i (.sys_clk_i, .rdata_i(rdata), .rbit_i(rbit),
    .rvalid_i(rvalid), .addr_o(addr), .ind_o(ind), .op_o(op), .wdat_o(wdat), .wbit_o(wbit));

  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  // Hang guard: the tests need well under a thousand cycles
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      error_cnt++;
      summarize();
    end
  end

  function automatic bit is_local(int a);
    return a >= 8'h81 && a <= 8'h93 && a != 8'h84;
  endfunction
  task automatic model_reset();
    foreach (exp_reg[a]) exp_reg[a] = 0;
    exp_reg[8'h81] = 8'h07;
    exp_reg[8'h90] = 8'hff;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] want);
    cmp_count++;
    if (got !== want) begin
      error_cnt++;
      $display("[FAIL] %0t byte got %h want %h", $time, got, want);
    end
  endtask
  task automatic chk_bit(input logic got, input logic want);
    cmp_count++;
    if (got !== want) begin
      error_cnt++;
      $display("[FAIL] %0t flag got %b want %b", $time, got, want);
    end
  endtask
  task automatic chk_regs();
    for (int i = 1; i < 20; i++) begin
      if (is_local(128 + i)) chk_byte(regs[i], 8'(exp_reg[128 + i]));
    end
  endtask
  // One access plus model update; reads are compared where the value is defined
  task automatic io(input logic [3:0] o, input logic i, input logic [7:0] a, input logic [7:0] d);
    core_access_model_i.access(o, i, a, d, rd, rb, rv);
    if (o[0] || o[2]) chk_bit(rv, 1'b1);
    if (o[0] && !i && is_local(a)) chk_byte(rd, 8'(exp_reg[a]));
    if (o[2] && !i && is_local(a & 8'hf8)) chk_bit(rb, exp_reg[a & 8'hf8][a[2:0]]);
    if (o[1] && !i && is_local(a)) exp_reg[a] = d;
    if (o[3] && !i && is_local(a & 8'hf8)) exp_reg[a & 8'hf8][a[2:0]] = d[0];
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    reset_i = 1'b1;
    void'($urandom(22));
    repeat (4) @(negedge sys_clk_i);
    reset_i = 1'b0;
    model_reset();
    chk_regs();
    // Every direct address: occupancy count and reset contents
    n = 0;
    for (int a = 0; a < 256; a++) begin
      io(4'h1, 1'b0, 8'(a), 8'h00);
      n += int'(occ);
      // Expected occupancy straight from the map; holes and low addresses hold nothing
      eo = a >= 128 && !special_register_space_pkg::RESERVED_MAP[a - 128];
      chk_bit(occ, eo);
      chk_bit(hit, is_local(a));
      chk_bit(cap, eo && a % 8 == 0);
    end
    chk_byte(8'(n), 8'h6a);
    io(4'h1, 1'b1, 8'h90, 8'h00);
    chk_bit(occ, 1'b0);
    chk_bit(hit, 1'b0);
    $display("scan done");
    // Random byte writes, direct then indirect, each read back
    for (int a = 128; a < 150; a++) begin
      io(4'h2, 1'b0, 8'(a), 8'($urandom));
      io(4'h2, 1'b1, 8'(a), 8'($urandom));
      io(4'h1, 1'b0, 8'(a), 8'h00);
    end
    chk_regs();
    $display("byte test done");
    // Bit writes and reads over both bit-capable local registers
    for (int i = 0; i < 16; i++) begin
      io(4'h8, 1'b0, 8'h88 + 8'(i), 8'($urandom));
      io(4'h4, 1'b0, 8'h88 + 8'(i), 8'h00);
    end
    chk_regs();
    $display("bit test done");
    // Second reset in mid-run restores the reset image
    @(negedge sys_clk_i);
    reset_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    reset_i = 1'b0;
    model_reset();
    chk_regs();
    io(4'h1, 1'b0, 8'h81, 8'h00);
    $display("reset test done");
    summarize();
  end
endmodule // tb_special_register_space_decode
